// *** rtl/irq_flags_pkg.sv ***
// Constants, field positions and carrier types of the interrupt flag block
package irq_flags_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word indices
  localparam logic [3:0] CTL_ONE_OFS    = 4'h0;
  localparam logic [3:0] CTL_TWO_OFS    = 4'h1;
  localparam logic [3:0] FLAGS_ZERO_OFS = 4'h2;
  localparam logic [3:0] FLAGS_ONE_OFS  = 4'h3;
  localparam logic [3:0] FLAGS_TWO_OFS  = 4'h4;
  localparam logic [3:0] FLAGS_THR_OFS  = 4'h5;
  localparam logic [3:0] EVT_STAT_OFS   = 4'h6;
  localparam logic [3:0] EVT_MASK_OFS   = 4'h7;

  // First control register
  localparam int ADDR_FAULT_BIT = 3;
  localparam int STACK_FAULT_BIT = 2;
  localparam int OSC_LOSS_BIT   = 1;
  localparam logic [15:0] CTL_ONE_MASK = 16'h000e;

  // Second control register
  localparam int ALT_VT_BIT     = 15;
  localparam int HOLDOFF_BIT    = 14;
  localparam int EXT2_POL_BIT   = 2;
  localparam int EXT1_POL_BIT   = 1;
  localparam int EXT0_POL_BIT   = 0;
  localparam logic [15:0] CTL_TWO_MASK = 16'hc007;
  localparam logic [15:0] CTL_TWO_WMASK = 16'h8007;

  // Flag register zero
  localparam int ADC_DONE_BIT   = 13;
  localparam int UART_TX_BIT    = 12;
  localparam int UART_RX_BIT    = 11;
  localparam int SPI_EVENT_BIT  = 10;
  localparam int SPI_FAULT_BIT  = 9;
  localparam int TIMER3_BIT     = 8;
  localparam int TIMER2_BIT     = 7;
  localparam int COMPARE2_BIT   = 6;
  localparam int CAPTURE2_BIT   = 5;
  localparam int TIMER1_BIT     = 3;
  localparam int COMPARE1_BIT   = 2;
  localparam int CAPTURE1_BIT   = 1;
  localparam int EXT_ZERO_BIT   = 0;
  localparam logic [15:0] FLAGS_ZERO_MASK = 16'h3fef;

  // Flag register one
  localparam int EXT_TWO_BIT    = 13;
  localparam int TIMER5_BIT     = 12;
  localparam int TIMER4_BIT     = 11;
  localparam int EXT_ONE_BIT    = 4;
  localparam int PIN_CHANGE_BIT = 3;
  localparam int COMPARATOR_BIT = 2;
  localparam int I2C_MASTER_BIT = 1;
  localparam int I2C_SLAVE_BIT  = 0;
  localparam logic [15:0] FLAGS_ONE_BASE  = 16'h201f;
  localparam logic [15:0] FLAGS_ONE_LARGE = 16'h1800;

  // Flag register two
  localparam int CAPTURE3_BIT   = 5;
  localparam logic [15:0] FLAGS_TWO_MASK = 16'h0020;

  // Flag register three
  localparam int PWM_FAULT_A_BIT = 15;
  localparam int RTC_EVENT_BIT   = 14;
  localparam int PWM_PERIOD_BIT  = 9;
  localparam logic [15:0] FLAGS_THR_BASE  = 16'h4000;
  localparam logic [15:0] FLAGS_THR_MOTOR = 16'h8200;

  // Event status and mask layout
  localparam int EVT_TRAP_BIT   = 0;
  localparam int EVT_EXT_BIT    = 1;
  localparam int EVT_PERIPH_BIT = 2;
  localparam int EVT_W          = 3;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic addr_fault;
    logic stack_fault;
    logic osc_loss;
  } trap_req_type;

  typedef struct packed {
    logic adc_done;
    logic uart_tx;
    logic uart_rx;
    logic spi_event;
    logic spi_fault;
    logic timer_three;
    logic timer_two;
    logic compare_two;
    logic capture_two;
    logic timer_one;
    logic compare_one;
    logic capture_one;
    logic timer_five;
    logic timer_four;
    logic pin_change;
    logic comparator;
    logic i2c_master_event;
    logic i2c_slave_event;
    logic capture_three;
    logic pwm_fault_a;
    logic rtc_event;
    logic pwm_period;
  } periph_req_type;

  typedef struct packed {
    logic [15:0] zero;
    logic [15:0] one;
    logic [15:0] two;
    logic [15:0] three;
  } flag_bank_type;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [2:0] edge_seen;
  } edge_state_type;

endpackage

// *** rtl/ext_edge_catcher.sv ***
// Synchroniser and polarity-selected edge detector for the external pins
`timescale 1ns/1ps
module ext_edge_catcher (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] pin,
  input  wire logic [2:0] falling_sel,
  output logic      [2:0] edge_pulse
);

  irq_flags_pkg::edge_state_type state_reg;
  irq_flags_pkg::edge_state_type state_next;

  always_comb begin
    state_next = state_reg;
    // sync1 feeds only sync2
    state_next.sync1 = pin;
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2;
    for (int i = 0; i < 3; i++) begin
      // One pulse per qualifying edge of the synchronised level
      if (falling_sel[i]) begin
        state_next.edge_seen[i] = state_reg.prev[i] & ~state_reg.sync2[i];
      end else begin
        state_next.edge_seen[i] = ~state_reg.prev[i] & state_reg.sync2[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign edge_pulse = state_reg.edge_seen;

endmodule

// *** rtl/interrupt_flag_and_control_regs.sv ***
// Interrupt request flags, trap status and global interrupt control
//
// Functional notes
// - Address fault trap sets control one bit 3
// - Stack fault trap sets control one bit 2
// - Oscillator loss trap sets control one bit 1
// - Unimplemented bits read zero, ignore writes
// - Bit 15 selects alternate vector table
// - Bit 14 reads timed holdoff state
// - Polarity bits pick falling or rising edge
// - Flag bits read/write, reset zero, set on request
// - Flag zero upper byte layout
// - Flag zero lower byte layout
// - Flag one external, change, comparator, I2C
// - Timer four/five flags on large variants
// - Flag two holds only capture three
// - Fault A and period flags, motor variants
// - RTC flag sits below fault flag
// - Flags stay set until software clears
// - Per-source enable gating lives outside this block
`timescale 1ns/1ps
module interrupt_flag_and_control_regs #(
  parameter bit HAVE_LARGE_MEM = 1'b1,
  parameter bit HAVE_MOTOR_CTL = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire irq_flags_pkg::bus_req_type    bus,
  output logic                        [15:0] rdata,
  input  wire irq_flags_pkg::trap_req_type   trap,
  input  wire irq_flags_pkg::periph_req_type periph,
  input  wire logic                   [2:0]  ext_pin,
  input  wire logic                          holdoff_in_progress,
  output logic                               alt_vector_table_sel,
  output irq_flags_pkg::flag_bank_type       flags,
  output irq_flags_pkg::trap_req_type        trap_flags,
  output logic                               irq
);

  typedef struct packed {
    logic [15:0] ctl_one;
    logic [15:0] ctl_two;
    irq_flags_pkg::flag_bank_type bank;
    logic [2:0]  evt_status;
    logic [2:0]  evt_mask;
    logic [15:0] rdata;
  } regs_state_type;

  regs_state_type state_reg;
  regs_state_type state_next;

  logic [2:0] ext_edge;

  // Implemented bits of a register; also used for read-back
  function automatic logic [15:0] impl_mask(input logic [3:0] addr);
    logic [15:0] m;
    m = 16'h0000;
    unique case (addr)
      irq_flags_pkg::CTL_ONE_OFS: begin
        m = irq_flags_pkg::CTL_ONE_MASK;
      end
      irq_flags_pkg::CTL_TWO_OFS: begin
        m = irq_flags_pkg::CTL_TWO_MASK;
      end
      irq_flags_pkg::FLAGS_ZERO_OFS: begin
        m = irq_flags_pkg::FLAGS_ZERO_MASK;
      end
      irq_flags_pkg::FLAGS_ONE_OFS: begin
        m = irq_flags_pkg::FLAGS_ONE_BASE;
        if (HAVE_LARGE_MEM) begin
          m = m | irq_flags_pkg::FLAGS_ONE_LARGE;
        end
      end
      irq_flags_pkg::FLAGS_TWO_OFS: begin
        m = irq_flags_pkg::FLAGS_TWO_MASK;
      end
      irq_flags_pkg::FLAGS_THR_OFS: begin
        m = irq_flags_pkg::FLAGS_THR_BASE;
        if (HAVE_MOTOR_CTL) begin
          m = m | irq_flags_pkg::FLAGS_THR_MOTOR;
        end
      end
      irq_flags_pkg::EVT_STAT_OFS: begin
        m = 16'h0007;
      end
      irq_flags_pkg::EVT_MASK_OFS: begin
        m = 16'h0007;
      end
      default: begin
        m = 16'h0000;
      end
    endcase
    return m;
  endfunction

  // Software write value merged into the held value, then masked
  function automatic logic [15:0] write_merge(
    input logic [15:0] held,
    input logic [3:0]  addr,
    input logic [3:0]  target,
    input logic        wr,
    input logic [15:0] wdata,
    input logic [15:0] wmask
  );
    logic [15:0] v;
    v = held;
    if (wr && addr == target) begin
      v = (held & ~wmask) | (wdata & wmask);
    end
    return v & impl_mask(target);
  endfunction

  ext_edge_catcher edge_catcher (
    .clk         (clk),
    .rst         (rst),
    .pin         (ext_pin),
    .falling_sel (state_reg.ctl_two[2:0]),
    .edge_pulse  (ext_edge)
  );

  always_comb begin
    logic [15:0] set_zero;
    logic [15:0] set_one;
    logic [15:0] set_two;
    logic [15:0] set_thr;
    logic [15:0] set_ctl;
    logic [2:0]  evt_set;
    logic [15:0] word;
    set_zero = 16'h0000;
    set_one  = 16'h0000;
    set_two  = 16'h0000;
    set_thr  = 16'h0000;
    set_ctl  = 16'h0000;
    evt_set  = 3'h0;
    word     = 16'h0000;
    state_next = state_reg;

    // Trap status bits
    set_ctl[irq_flags_pkg::ADDR_FAULT_BIT]  = trap.addr_fault;
    set_ctl[irq_flags_pkg::STACK_FAULT_BIT] = trap.stack_fault;
    set_ctl[irq_flags_pkg::OSC_LOSS_BIT]    = trap.osc_loss;

    // Flag register zero
    set_zero[irq_flags_pkg::ADC_DONE_BIT]   = periph.adc_done;
    set_zero[irq_flags_pkg::UART_TX_BIT]    = periph.uart_tx;
    set_zero[irq_flags_pkg::UART_RX_BIT]    = periph.uart_rx;
    set_zero[irq_flags_pkg::SPI_EVENT_BIT]  = periph.spi_event;
    set_zero[irq_flags_pkg::SPI_FAULT_BIT]  = periph.spi_fault;
    set_zero[irq_flags_pkg::TIMER3_BIT]     = periph.timer_three;
    set_zero[irq_flags_pkg::TIMER2_BIT]     = periph.timer_two;
    set_zero[irq_flags_pkg::COMPARE2_BIT]   = periph.compare_two;
    set_zero[irq_flags_pkg::CAPTURE2_BIT]   = periph.capture_two;
    set_zero[irq_flags_pkg::TIMER1_BIT]     = periph.timer_one;
    set_zero[irq_flags_pkg::COMPARE1_BIT]   = periph.compare_one;
    set_zero[irq_flags_pkg::CAPTURE1_BIT]   = periph.capture_one;
    set_zero[irq_flags_pkg::EXT_ZERO_BIT]   = ext_edge[0];

    // Flag register one
    set_one[irq_flags_pkg::EXT_TWO_BIT]     = ext_edge[2];
    set_one[irq_flags_pkg::TIMER5_BIT]      = periph.timer_five;
    set_one[irq_flags_pkg::TIMER4_BIT]      = periph.timer_four;
    set_one[irq_flags_pkg::EXT_ONE_BIT]     = ext_edge[1];
    set_one[irq_flags_pkg::PIN_CHANGE_BIT]  = periph.pin_change;
    set_one[irq_flags_pkg::COMPARATOR_BIT]  = periph.comparator;
    set_one[irq_flags_pkg::I2C_MASTER_BIT]  = periph.i2c_master_event;
    set_one[irq_flags_pkg::I2C_SLAVE_BIT]   = periph.i2c_slave_event;

    // Flag registers two and three
    set_two[irq_flags_pkg::CAPTURE3_BIT]    = periph.capture_three;
    set_thr[irq_flags_pkg::PWM_FAULT_A_BIT] = periph.pwm_fault_a;
    set_thr[irq_flags_pkg::RTC_EVENT_BIT]   = periph.rtc_event;
    set_thr[irq_flags_pkg::PWM_PERIOD_BIT]  = periph.pwm_period;

    // Absent variant sources are dropped here so they never latch
    set_one = set_one & impl_mask(irq_flags_pkg::FLAGS_ONE_OFS);
    set_thr = set_thr & impl_mask(irq_flags_pkg::FLAGS_THR_OFS);

    // Hardware set wins over a software clear in the same cycle
    state_next.ctl_one = write_merge(state_reg.ctl_one, bus.addr,
      irq_flags_pkg::CTL_ONE_OFS, bus.wr, bus.wdata,
      irq_flags_pkg::CTL_ONE_MASK) | set_ctl;

    state_next.ctl_two = write_merge(state_reg.ctl_two, bus.addr,
      irq_flags_pkg::CTL_TWO_OFS, bus.wr, bus.wdata,
      irq_flags_pkg::CTL_TWO_WMASK);
    // Holdoff bit is read-only and follows the core's timer
    state_next.ctl_two[irq_flags_pkg::HOLDOFF_BIT] =
      holdoff_in_progress;

    state_next.bank.zero = write_merge(state_reg.bank.zero, bus.addr,
      irq_flags_pkg::FLAGS_ZERO_OFS, bus.wr, bus.wdata,
      16'hffff) | set_zero;
    state_next.bank.one = write_merge(state_reg.bank.one, bus.addr,
      irq_flags_pkg::FLAGS_ONE_OFS, bus.wr, bus.wdata,
      16'hffff) | set_one;
    state_next.bank.two = write_merge(state_reg.bank.two, bus.addr,
      irq_flags_pkg::FLAGS_TWO_OFS, bus.wr, bus.wdata,
      16'hffff) | set_two;
    state_next.bank.three = write_merge(state_reg.bank.three, bus.addr,
      irq_flags_pkg::FLAGS_THR_OFS, bus.wr, bus.wdata,
      16'hffff) | set_thr;

    // Event summary: write one to clear, set wins
    evt_set[irq_flags_pkg::EVT_TRAP_BIT]   = |set_ctl;
    evt_set[irq_flags_pkg::EVT_EXT_BIT]    = |ext_edge;
    evt_set[irq_flags_pkg::EVT_PERIPH_BIT] =
      |{set_zero, set_one, set_two, set_thr};
    if (bus.wr && bus.addr == irq_flags_pkg::EVT_STAT_OFS) begin
      state_next.evt_status = state_reg.evt_status & ~bus.wdata[2:0];
    end
    state_next.evt_status = state_next.evt_status | evt_set;
    if (bus.wr && bus.addr == irq_flags_pkg::EVT_MASK_OFS) begin
      state_next.evt_mask = bus.wdata[2:0];
    end

    // Read data stand in the cycle after the strobe only
    if (bus.rd) begin
      unique case (bus.addr)
        irq_flags_pkg::CTL_ONE_OFS: begin
          word = state_reg.ctl_one;
        end
        irq_flags_pkg::CTL_TWO_OFS: begin
          word = state_reg.ctl_two;
        end
        irq_flags_pkg::FLAGS_ZERO_OFS: begin
          word = state_reg.bank.zero;
        end
        irq_flags_pkg::FLAGS_ONE_OFS: begin
          word = state_reg.bank.one;
        end
        irq_flags_pkg::FLAGS_TWO_OFS: begin
          word = state_reg.bank.two;
        end
        irq_flags_pkg::FLAGS_THR_OFS: begin
          word = state_reg.bank.three;
        end
        irq_flags_pkg::EVT_STAT_OFS: begin
          word = {13'h0000, state_reg.evt_status};
        end
        irq_flags_pkg::EVT_MASK_OFS: begin
          word = {13'h0000, state_reg.evt_mask};
        end
        default: begin
          word = 16'h0000;
        end
      endcase
      state_next.rdata = word & impl_mask(bus.addr);
    end else begin
      state_next.rdata = irq_flags_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign alt_vector_table_sel =
    state_reg.ctl_two[irq_flags_pkg::ALT_VT_BIT];
  // Raw flags go to the enable logic, which gates them per source
  assign flags = state_reg.bank;
  assign trap_flags.addr_fault =
    state_reg.ctl_one[irq_flags_pkg::ADDR_FAULT_BIT];
  assign trap_flags.stack_fault =
    state_reg.ctl_one[irq_flags_pkg::STACK_FAULT_BIT];
  assign trap_flags.osc_loss =
    state_reg.ctl_one[irq_flags_pkg::OSC_LOSS_BIT];
  assign irq = |(state_reg.evt_status & state_reg.evt_mask);

endmodule

// *** sim/irq_flags_chk.sv ***
// Concurrent checks on the ports of the interrupt flag block
`timescale 1ns/1ps
module irq_flags_chk (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire irq_flags_pkg::bus_req_type    bus,
  input wire logic                   [15:0] rdata,
  input wire irq_flags_pkg::trap_req_type   trap,
  input wire irq_flags_pkg::periph_req_type periph,
  input wire logic                   [2:0]  ext_pin,
  input wire logic                          holdoff_in_progress,
  input wire logic                          alt_vector_table_sel,
  input wire irq_flags_pkg::flag_bank_type  flags,
  input wire irq_flags_pkg::trap_req_type   trap_flags,
  input wire logic                          irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_trap_set;
    trap != 3'h0 |=> (trap_flags & $past(trap)) == $past(trap);
  endproperty
  a_trap_set: assert property (p_trap_set)
    else $error("trap status bit not set");

  property p_unimpl;
    flags.zero[15:14] == 2'h0 && !flags.zero[4] && flags.one[15:14] == 2'h0
      && flags.one[10:5] == 6'h0 && flags.two[15:6] == 10'h0
      && flags.two[4:0] == 5'h0 && flags.three[13:10] == 4'h0
      && flags.three[8:0] == 9'h0;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unused flag bit set");

  property p_alt_vt;
    bus.wr && bus.addr == 4'h1 |=> alt_vector_table_sel == $past(bus.wdata[15]);
  endproperty
  a_alt_vt: assert property (p_alt_vt)
    else $error("vector table select not written");

  property p_holdoff;
    bus.rd && bus.addr == 4'h1 && $stable(holdoff_in_progress)
      |=> rdata[14] == $past(holdoff_in_progress);
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("holdoff status bit wrong");

  property p_sticky;
    !$past(bus.wr) |-> (flags & $past(flags)) == $past(flags);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag cleared without a write");

  property p_adc;
    periph.adc_done |=> flags.zero[13];
  endproperty
  a_adc: assert property (p_adc)
    else $error("adc flag not set");

  property p_timer_two;
    periph.timer_two |=> flags.zero[7];
  endproperty
  a_timer_two: assert property (p_timer_two)
    else $error("timer two flag not set");

  property p_pin_change;
    periph.pin_change |=> flags.one[3];
  endproperty
  a_pin_change: assert property (p_pin_change)
    else $error("pin change flag not set");

  property p_timer_five;
    periph.timer_five |=> flags.one[12];
  endproperty
  a_timer_five: assert property (p_timer_five)
    else $error("timer five flag not set");

  property p_rtc;
    periph.rtc_event |=> flags.three[14] && !flags.three[13];
  endproperty
  a_rtc: assert property (p_rtc)
    else $error("rtc flag not set");
endmodule

bind interrupt_flag_and_control_regs irq_flags_chk i_irq_flags_chk (
  .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .trap(trap),
  .periph(periph), .ext_pin(ext_pin),
  .holdoff_in_progress(holdoff_in_progress),
  .alt_vector_table_sel(alt_vector_table_sel), .flags(flags),
  .trap_flags(trap_flags), .irq(irq));

// *** sim/irq_sources.sv ***
// Model of the peripherals, pins and core that raise events
`timescale 1ns/1ps
module irq_sources (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic              [2:0]  trap_go,
  input  wire logic              [21:0] periph_go,
  input  wire logic              [2:0]  pin_lvl,
  input  wire logic                     holdoff_lvl,
  output irq_flags_pkg::trap_req_type   trap,
  output irq_flags_pkg::periph_req_type periph,
  output logic                   [2:0]  ext_pin,
  output logic                          holdoff
);
  // Requests leave as one-cycle pulses, so stickiness is the block's job
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap    <= '0;
      periph  <= '0;
      ext_pin <= 3'h0;
      holdoff <= 1'b0;
    end else begin
      trap    <= irq_flags_pkg::trap_req_type'(trap_go);
      periph  <= irq_flags_pkg::periph_req_type'(periph_go);
      ext_pin <= pin_lvl;
      holdoff <= holdoff_lvl;
    end
  end
endmodule

// *** sim/interrupt_flag_and_control_regs_tb.sv ***
// Self-checking bench of the interrupt flag and control block
`timescale 1ns/1ps
module interrupt_flag_and_control_regs_tb;
  logic                          clk;
  logic                          rst;
  irq_flags_pkg::bus_req_type    bus;
  logic                   [15:0] rdata;
  irq_flags_pkg::trap_req_type   trap;
  irq_flags_pkg::trap_req_type   trap_flags;
  irq_flags_pkg::periph_req_type periph;
  irq_flags_pkg::flag_bank_type  flags;
  logic                   [2:0]  ext_pin;
  logic                   [2:0]  trap_go;
  logic                   [2:0]  pin_lvl;
  logic                   [21:0] periph_go;
  logic                          holdoff;
  logic                          holdoff_lvl;
  logic                          alt_vt;
  logic                          irq;
  int                            num_errors = 0;
  int                            samples_checked = 0;
  int                            cycles = 0;
  // Request bits msb first: register index and the bit it must set
  logic                   [7:0]  row [22] = '{8'h2d, 8'h2c, 8'h2b, 8'h2a,
    8'h29, 8'h28, 8'h27, 8'h26, 8'h25, 8'h23, 8'h22, 8'h21, 8'h3c, 8'h3b,
    8'h33, 8'h32, 8'h31, 8'h30, 8'h45, 8'h5f, 8'h5e, 8'h59};
  // Index and read-back after writing all ones
  logic                   [19:0] ones [8] = '{20'h0000e, 20'h18007,
    20'h23fef, 20'h3381f, 20'h40020, 20'h5c200, 20'h70007, 20'h80000};
  logic                   [31:0] ext_exp [3] = '{32'h0001_0000,
    32'h0000_0010, 32'h0000_2000};

  interrupt_flag_and_control_regs i_interrupt_flag_and_control_regs (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .trap(trap),
    .periph(periph), .ext_pin(ext_pin), .holdoff_in_progress(holdoff),
    .alt_vector_table_sel(alt_vt), .flags(flags), .trap_flags(trap_flags),
    .irq(irq));

  irq_sources i_irq_sources (
    .clk(clk), .rst(rst), .trap_go(trap_go), .periph_go(periph_go),
    .pin_lvl(pin_lvl), .holdoff_lvl(holdoff_lvl), .trap(trap),
    .periph(periph), .ext_pin(ext_pin), .holdoff(holdoff));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang costs one error and still reaches the verdict
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk) bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 cmp("rdata", {16'h0, e}, {16'h0, rdata});
  endtask

  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    rst = 1'b1;
    bus = '0;
    trap_go = 3'h0;
    periph_go = 22'h0;
    pin_lvl = 3'h0;
    holdoff_lvl = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 22; i++) begin
      @(posedge clk) periph_go <= 22'h1 << (21 - i);
      @(posedge clk) periph_go <= 22'h0;
      settle(2);
      rd(row[i][7:4], 16'h1 << row[i][3:0]);
      wr(row[i][7:4], 16'h0);
      rd(row[i][7:4], 16'h0);
    end
    foreach (ones[i]) begin
      wr(ones[i][19:16], 16'hffff);
      rd(ones[i][19:16], ones[i][15:0]);
    end
    cmp("alt_vt", 32'h1, {31'h0, alt_vt});
    // Reset lands mid-run on registers full of ones
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0);
    cmp("alt_vt", 32'h0, {31'h0, alt_vt});
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) trap_go <= 3'h1 << k;
      @(posedge clk) trap_go <= 3'h0;
      settle(2);
      rd(4'h0, 16'h2 << k);
      wr(4'h0, 16'h0);
    end
    @(posedge clk) holdoff_lvl <= 1'b1;
    settle(3);
    wr(4'h1, 16'h4000);
    rd(4'h1, 16'h4000);
    @(posedge clk) holdoff_lvl <= 1'b0;
    settle(3);
    rd(4'h1, 16'h0);
    for (int p = 0; p < 2; p++) begin
      wr(4'h1, p[0] ? 16'h0007 : 16'h0000);
      @(posedge clk) pin_lvl <= {3{p[0]}};
      for (int k = 0; k < 3; k++) begin
        settle(8);
        wr(4'h2, 16'h0);
        wr(4'h3, 16'h0);
        @(posedge clk) pin_lvl[k] <= !p[0];
        settle(8);
        cmp("ext flags", ext_exp[k], {flags.zero, flags.one});
        wr(4'h2, 16'h0);
        wr(4'h3, 16'h0);
        @(posedge clk) pin_lvl[k] <= p[0];
        settle(8);
        cmp("ext flags", 32'h0, {flags.zero, flags.one});
      end
    end
    wr(4'h6, 16'h0007);
    @(posedge clk) trap_go <= 3'h4;
    @(posedge clk) trap_go <= 3'h0;
    settle(3);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(4'h7, 16'h0001);
    settle(2);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(4'h6, 16'h0001);
    settle(2);
    cmp("irq", 32'h0, {31'h0, irq});
    end_sim();
  end
endmodule
